// ---- pkg/chip_control_pkg.sv ----
// constants for the upper chip control register bank
// assumes a 100 MHz core clock and a 32-bit configuration access port
package chip_control_pkg;
  localparam logic [7:0]  CHIP_CONTROL_ZERO_OFFSET = 8'h40;
  localparam int          CLK_PERIOD_NS            = 10;
  localparam int          FC_UPDATE_BIT            = 15;
  localparam int          RETRY_STATUS_BIT         = 16;
  localparam int          RETRY_LIMIT_LSB          = 17;
  localparam int          DISCARD_DIS_BIT          = 19;
  localparam int          DISCARD_SHORT_BIT        = 20;
  localparam int          CFG_RETRY_LSB            = 21;
  localparam int          DT_ORDER_BIT             = 23;
  localparam int          CPL_TIMER_LSB            = 24;
  localparam int          ISOC_EN_BIT              = 26;
  localparam int          ISOC_TC_LSB              = 27;
  localparam int          LOOPBACK_BIT             = 30;
  localparam int          LOCKOUT_BIT              = 31;
  localparam logic [1:0]  RETRY_LIMIT_RESET        = 2'h0;
  localparam logic [1:0]  CFG_RETRY_RESET          = 2'h1;
  localparam logic [1:0]  CPL_TIMER_RESET          = 2'h1;
  localparam logic [2:0]  ISOC_TC_RESET            = 3'h1;
  localparam logic [2:0]  TC_ZERO                  = 3'h0;
  localparam logic [31:0] RETRY_LIMIT_256          = 32'h0000_0100;
  localparam logic [31:0] RETRY_LIMIT_64K          = 32'h0001_0000;
  localparam logic [31:0] RETRY_LIMIT_2G           = 32'h8000_0000;
  localparam logic [7:0]  DISCARD_SHORT_CLKS       = 8'h40;
  localparam int          CFG_RETRY_US_0           = 25;
  localparam int          CFG_RETRY_US_1           = 500;
  localparam int          CFG_RETRY_US_2           = 5000;
  localparam int          CFG_RETRY_US_3           = 25000;
  localparam int          CPL_US_0                 = 50;
  localparam int          CPL_US_1                 = 10000;
  localparam int          CPL_US_2                 = 50000;
  localparam logic [1:0]  CPL_TIMER_OFF            = 2'h3;
endpackage : chip_control_pkg

// ---- rtl/chip_control_upper.sv ----
// upper half (bits 31:15) of the chip control register and the timers it steers
// assumes the configuration port is on the core clock; straps and test pins are asynchronous
// Operation
// [RL1] bit 15 low sends a credit update per two freed credits, high per freed credit; resets 0.
// [RL2] bit 16 is set when the retry counter expires, stays set until cleared, resets 0.
// [RL3] bits 18:17 pick no limit, 256, 64K or 2G retries; reset 00.
// [RL4] bit 19 set disables the discard timer together with the bridge control enable; resets 0.
// [RL5] bit 20 set makes the discard timer 64 clocks, else the bridge control bit by direction.
// [RL6] bits 22:21 pick the config retry timer 25us, 0.5ms, 5ms or 25ms; reset 01.
// [RL7] bit 23 low allows out-of-order delayed completions, high forces order; resets 0.
// [RL8] bits 25:24 pick completion timeout 50us, 10ms, 50ms or off; reset 01.
// [RL9] bit 26 low tags every upstream memory transaction with traffic class zero; resets 0.
// [RL10] bit 26 high uses the traffic class in bits 29:27, which reset to 001.
// [RL11] bit 30 loops transmit to receive only with the five test and strap pins at their levels.
// [RL12] bit 30 is writable only in reverse bridge mode, read-only in forward; resets 0.
// [RL13] bit 31 set allows configuration access only from the secondary interface.
// [RL14] a locked primary access gets a retry-status completion forward or target retry reverse.
// [RL15] bit 31 resets to 0 while test_mode_pin_zero is low.
// [RL16] writing 1 to bit 16 clears it, writing 0 leaves it.
`timescale 1ns/1ps
module chip_control_upper #(
  parameter int CPL_US_2_CLKS = chip_control_pkg::CPL_US_2 * 1000 / chip_control_pkg::CLK_PERIOD_NS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cfg_valid,
  input  wire logic        i_cfg_write,
  input  wire logic        i_cfg_primary,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic [3:0]  i_cfg_be,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_ack,
  output logic             o_cfg_crs,
  output logic             o_cfg_target_retry,
  input  wire logic        i_test_mode_pin_zero,
  input  wire logic        i_test_mode_pin_one,
  input  wire logic        i_test_mode_pin_two,
  input  wire logic        i_mask_input_strap,
  input  wire logic        i_reverse_mode_strap,
  input  wire logic        i_discard_enable,
  input  wire logic        i_fwd_discard_long,
  input  wire logic        i_rev_discard_long,
  input  wire logic        i_retry_event,
  input  wire logic        i_retry_clear,
  input  wire logic        i_credit_freed,
  input  wire logic        i_cfg_retry_start,
  input  wire logic        i_cfg_retry_stop,
  input  wire logic        i_cpl_start,
  input  wire logic        i_cpl_stop,
  input  wire logic        i_mem_upstream,
  output logic             o_fc_update,
  output logic             o_discard_active,
  output logic             o_discard_short,
  output logic [7:0]       o_discard_select,
  output logic             o_in_order,
  output logic [2:0]       o_traffic_class,
  output logic             o_loopback,
  output logic             o_cfg_retry_expired,
  output logic             o_cpl_expired
);
  localparam int CFG0 = chip_control_pkg::CFG_RETRY_US_0 * 1000 / chip_control_pkg::CLK_PERIOD_NS;
  localparam int CFG1 = chip_control_pkg::CFG_RETRY_US_1 * 1000 / chip_control_pkg::CLK_PERIOD_NS;
  localparam int CFG2 = chip_control_pkg::CFG_RETRY_US_2 * 1000 / chip_control_pkg::CLK_PERIOD_NS;
  localparam int CFG3 = chip_control_pkg::CFG_RETRY_US_3 * 1000 / chip_control_pkg::CLK_PERIOD_NS;
  localparam int CPL0 = chip_control_pkg::CPL_US_0 * 1000 / chip_control_pkg::CLK_PERIOD_NS;
  localparam int CPL1 = chip_control_pkg::CPL_US_1 * 1000 / chip_control_pkg::CLK_PERIOD_NS;

  logic        fc_q;
  logic        retry_stat_q;
  logic [1:0]  retry_lim_q;
  logic        discard_dis_q;
  logic        discard_short_q;
  logic [1:0]  cfg_retry_q;
  logic        order_q;
  logic [1:0]  cpl_q;
  logic        isoc_q;
  logic [2:0]  tc_q;
  logic        loop_q;
  logic        lock_q;
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic [4:0]  pin_s3_q;
  logic [4:0]  pin_q;
  logic        reverse;
  logic        hit;
  logic        wr;
  logic        locked_access;
  logic [31:0] retry_cnt_q;
  logic [31:0] retry_limit;
  logic        credit_half_q;
  logic [31:0] cfg_limit;
  logic [31:0] cpl_limit;
  logic        cpl_stop;
  logic [31:0] reg_value;

  // three-stage pin synchroniser; value moves only once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    pin_s1_q <= {i_reverse_mode_strap, i_mask_input_strap, i_test_mode_pin_two,
                 i_test_mode_pin_one, i_test_mode_pin_zero};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_q <= 5'h00;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (pin_s2_q[k] == pin_s3_q[k]) begin
          pin_q[k] <= pin_s3_q[k];
        end
      end
    end
  end

  assign reverse       = pin_q[4];
  assign hit           = i_cfg_valid && (i_cfg_addr == chip_control_pkg::CHIP_CONTROL_ZERO_OFFSET);
  assign locked_access = i_cfg_valid && i_cfg_primary && lock_q; // [RL13]
  assign wr            = hit && i_cfg_write && !locked_access;

  // configuration port answers; locked primary accesses are refused per bridge direction
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cfg_ack          <= 1'b0;
      o_cfg_crs          <= 1'b0;
      o_cfg_target_retry <= 1'b0;
      o_cfg_rdata        <= 32'h0000_0000;
    end else begin
      o_cfg_ack          <= i_cfg_valid && !locked_access;
      o_cfg_crs          <= locked_access && !reverse; // [RL14]
      o_cfg_target_retry <= locked_access && reverse; // [RL14]
      o_cfg_rdata        <= (hit && !i_cfg_write && !locked_access) ? reg_value : 32'h0000_0000;
    end
  end

  // plain read-write fields; byte lanes 1 to 3 cover bits 15 to 31
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fc_q            <= 1'b0; // [RL1]
      retry_lim_q     <= chip_control_pkg::RETRY_LIMIT_RESET; // [RL3]
      discard_dis_q   <= 1'b0; // [RL4]
      discard_short_q <= 1'b0;
      cfg_retry_q     <= chip_control_pkg::CFG_RETRY_RESET; // [RL6]
      order_q         <= 1'b0; // [RL7]
      cpl_q           <= chip_control_pkg::CPL_TIMER_RESET; // [RL8]
      isoc_q          <= 1'b0; // [RL9]
      tc_q            <= chip_control_pkg::ISOC_TC_RESET; // [RL10]
    end else if (wr) begin
      if (i_cfg_be[1]) begin
        fc_q <= i_cfg_wdata[chip_control_pkg::FC_UPDATE_BIT];
      end
      if (i_cfg_be[2]) begin
        retry_lim_q     <= i_cfg_wdata[chip_control_pkg::RETRY_LIMIT_LSB +: 2];
        discard_dis_q   <= i_cfg_wdata[chip_control_pkg::DISCARD_DIS_BIT];
        discard_short_q <= i_cfg_wdata[chip_control_pkg::DISCARD_SHORT_BIT];
        cfg_retry_q     <= i_cfg_wdata[chip_control_pkg::CFG_RETRY_LSB +: 2];
        order_q         <= i_cfg_wdata[chip_control_pkg::DT_ORDER_BIT];
      end
      if (i_cfg_be[3]) begin
        cpl_q  <= i_cfg_wdata[chip_control_pkg::CPL_TIMER_LSB +: 2];
        isoc_q <= i_cfg_wdata[chip_control_pkg::ISOC_EN_BIT];
        tc_q   <= i_cfg_wdata[chip_control_pkg::ISOC_TC_LSB +: 3];
      end
    end
  end

  // loopback writable only in reverse mode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      loop_q <= 1'b0; // [RL12]
    end else if (wr && i_cfg_be[3] && reverse) begin
      loop_q <= i_cfg_wdata[chip_control_pkg::LOOPBACK_BIT]; // [RL12]
    end
  end

  // lockout reset is conditional on the test pin; with the pin high it keeps its value
  always_ff @(posedge i_core_clk) begin
    if (i_rst && !i_test_mode_pin_zero) begin
      lock_q <= 1'b0; // [RL15]
    end else if (wr && i_cfg_be[3]) begin
      lock_q <= i_cfg_wdata[chip_control_pkg::LOCKOUT_BIT];
    end
  end

  // retry counter against the selected limit
  always_comb begin
    unique case (retry_lim_q)
      2'h0: retry_limit = 32'h0000_0000;
      2'h1: retry_limit = chip_control_pkg::RETRY_LIMIT_256;
      2'h2: retry_limit = chip_control_pkg::RETRY_LIMIT_64K;
      2'h3: retry_limit = chip_control_pkg::RETRY_LIMIT_2G;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_retry_clear) begin
      retry_cnt_q <= 32'h0000_0000;
    end else if (i_retry_event && retry_limit != 32'h0000_0000) begin
      retry_cnt_q <= (retry_cnt_q + 32'h0000_0001 >= retry_limit) ? 32'h0000_0000
                                                                 : retry_cnt_q + 32'h0000_0001;
    end
  end

  logic retry_expire;
  assign retry_expire = i_retry_event && !i_retry_clear && (retry_limit != 32'h0000_0000) &&
                        (retry_cnt_q + 32'h0000_0001 >= retry_limit); // [RL3]

  // expiry wins over a same-cycle software clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      retry_stat_q <= 1'b0;
    end else if (retry_expire) begin
      retry_stat_q <= 1'b1; // [RL2]
    end else if (wr && i_cfg_be[2] && i_cfg_wdata[chip_control_pkg::RETRY_STATUS_BIT]) begin
      retry_stat_q <= 1'b0; // [RL16]
    end
  end

  // credit update pacing
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      credit_half_q <= 1'b0;
      o_fc_update   <= 1'b0;
    end else begin
      o_fc_update <= i_credit_freed && (fc_q || credit_half_q); // [RL1]
      if (i_credit_freed) begin
        credit_half_q <= fc_q ? 1'b0 : !credit_half_q;
      end
    end
  end

  always_comb begin
    unique case (cfg_retry_q)
      2'h0: cfg_limit = 32'(CFG0);
      2'h1: cfg_limit = 32'(CFG1);
      2'h2: cfg_limit = 32'(CFG2);
      2'h3: cfg_limit = 32'(CFG3);
    endcase
    unique case (cpl_q)
      2'h0: cpl_limit = 32'(CPL0);
      2'h1: cpl_limit = 32'(CPL1);
      2'h2: cpl_limit = 32'(CPL_US_2_CLKS);
      2'h3: cpl_limit = 32'h0000_0000;
    endcase
  end

  cycle_timer u_cfg_retry_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (i_cfg_retry_start),
    .i_stop     (i_cfg_retry_stop),
    .i_limit    (cfg_limit),
    .o_running  (),
    .o_expired  (o_cfg_retry_expired)
  ); // [RL6]

  assign cpl_stop = i_cpl_stop || (cpl_q == chip_control_pkg::CPL_TIMER_OFF);

  cycle_timer u_cpl_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (i_cpl_start),
    .i_stop     (cpl_stop),
    .i_limit    (cpl_limit),
    .o_running  (),
    .o_expired  (o_cpl_expired)
  ); // [RL8]

  // control outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_discard_active <= 1'b0;
      o_discard_short  <= 1'b0;
      o_discard_select <= 8'h00;
      o_in_order       <= 1'b0;
      o_traffic_class  <= 3'h0;
      o_loopback       <= 1'b0;
    end else begin
      o_discard_active <= i_discard_enable && !discard_dis_q; // [RL4]
      o_discard_short  <= discard_short_q; // [RL5]
      o_discard_select <= discard_short_q ? chip_control_pkg::DISCARD_SHORT_CLKS
                        : {7'h00, reverse ? i_rev_discard_long : i_fwd_discard_long}; // [RL5]
      o_in_order       <= order_q; // [RL7]
      o_traffic_class  <= (i_mem_upstream && isoc_q) ? tc_q : chip_control_pkg::TC_ZERO; // [RL9]
      o_loopback       <= loop_q && (pin_q == 5'h1E); // [RL11]
    end
  end

  always_comb begin
    reg_value = 32'h0000_0000;
    reg_value[chip_control_pkg::FC_UPDATE_BIT]          = fc_q;
    reg_value[chip_control_pkg::RETRY_STATUS_BIT]       = retry_stat_q;
    reg_value[chip_control_pkg::RETRY_LIMIT_LSB +: 2]   = retry_lim_q;
    reg_value[chip_control_pkg::DISCARD_DIS_BIT]        = discard_dis_q;
    reg_value[chip_control_pkg::DISCARD_SHORT_BIT]      = discard_short_q;
    reg_value[chip_control_pkg::CFG_RETRY_LSB +: 2]     = cfg_retry_q;
    reg_value[chip_control_pkg::DT_ORDER_BIT]           = order_q;
    reg_value[chip_control_pkg::CPL_TIMER_LSB +: 2]     = cpl_q;
    reg_value[chip_control_pkg::ISOC_EN_BIT]            = isoc_q;
    reg_value[chip_control_pkg::ISOC_TC_LSB +: 3]       = tc_q;
    reg_value[chip_control_pkg::LOOPBACK_BIT]           = loop_q;
    reg_value[chip_control_pkg::LOCKOUT_BIT]            = lock_q;
  end

  AST_LOCK_CRS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (locked_access && !reverse) |=> (o_cfg_crs && !o_cfg_ack)) else $error("no crs"); // [RL14]
  AST_STAT_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
    retry_expire |=> retry_stat_q) else $error("status not set"); // [RL2]
  AST_FWD_LOOP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !reverse |=> $stable(loop_q)) else $error("loop written forward"); // [RL12]
  AST_TC0: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !isoc_q |=> o_traffic_class == 3'h0) else $error("tc not zero"); // [RL9]
  AST_LOCK_TR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (locked_access && reverse) |=> (o_cfg_target_retry && !o_cfg_ack)) else $error("no retry"); // [RL14]
  AST_FC_SKIP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_credit_freed && !fc_q && !credit_half_q) |=> !o_fc_update) else $error("early update"); // [RL1]
  AST_LOOP_PINS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (loop_q && pin_q != 5'h1E) |=> !o_loopback) else $error("loop without pins"); // [RL11]
endmodule : chip_control_upper

// ---- rtl/cycle_timer.sv ----
// one-shot down counter: loads a limit on start, pulses on expiry
// assumes start and stop come from logic on the same clock
`timescale 1ns/1ps
module cycle_timer (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic [31:0] i_limit,
  output logic             o_running,
  output logic             o_expired
);
  logic [31:0] count_q;
  logic        run_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_stop) begin
      run_q   <= 1'b0;
      count_q <= 32'h0000_0000;
    end else if (i_start) begin
      run_q   <= (i_limit != 32'h0000_0000);
      count_q <= i_limit;
    end else if (run_q) begin
      count_q <= count_q - 32'h0000_0001;
      if (count_q == 32'h0000_0001) begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= run_q && !i_stop && !i_start && (count_q == 32'h0000_0001);
    end
  end

  assign o_running = run_q;
endmodule : cycle_timer

// ---- verif/cfg_host_model.sv ----
// configuration host model: issues one access at a time on the configuration port
// assumes the block registers its answer on the edge that takes the strobe
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        i_core_clk,
  output logic             o_valid,
  output logic             o_write,
  output logic             o_primary,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_be
);
  logic        busy;
  logic [31:0] junk_q;
  logic [45:0] req;
  // idle fields toggle every cycle so a stale request never passes for a live one
  always @(posedge i_core_clk) junk_q <= ~junk_q;
  assign o_valid = busy;
  assign {o_write, o_primary, o_addr, o_wdata, o_be} = busy ? req : {junk_q[13:0], junk_q};
  initial begin
    busy   = 1'b0;
    junk_q = 32'hA5C3_5A3C;
    req    = '0;
  end
  // request held from just after one edge until the taking edge, then released
  task automatic access(input logic w, input logic p, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] be);
    @(posedge i_core_clk);
    #1;
    req  = {w, p, a, d, be};
    busy = 1'b1;
    @(posedge i_core_clk);
    #1;
    busy = 1'b0;
  endtask : access
endmodule : cfg_host_model

// ---- verif/chip_control_upper_tb.sv ----
// self-checking bench for the upper chip control register bank
// assumes the host model drives the config port and the answer follows one cycle later
`timescale 1ns/1ps
module chip_control_upper_tb;
  typedef struct {logic [2:0] kind; logic rd; logic [31:0] mask; logic [31:0] data;} note_type;
  localparam logic [7:0] OFF = chip_control_pkg::CHIP_CONTROL_ZERO_OFFSET;
  logic        clk, rst, valid, write, primary, pin0, pin1, pin2, mask_s, rev;
  logic        disc_en, fwd_long, rev_long, rty_ev, rty_clr, credit, crs_s, crs_p;
  logic        cpl_s, cpl_p, mem_up, ack, crs, tretry, fc, dact, dshort, ord, lb, crs_x, cpl_x;
  logic [7:0]  addr, dsel;
  logic [31:0] wdata, rdata, shadow, d;
  logic [3:0]  be;
  logic [2:0]  tc;
  int          errors, cmp_count, fc_cnt, n;
  int          seed = 32'h95ff;
  note_type    expq[$];
  note_type    e;

  cfg_host_model i_host (.i_core_clk(clk), .o_valid(valid), .o_write(write),
    .o_primary(primary), .o_addr(addr), .o_wdata(wdata), .o_be(be));
  chip_control_upper #(.CPL_US_2_CLKS(100)) i_dut (.i_core_clk(clk), .i_rst(rst),
    .i_cfg_valid(valid), .i_cfg_write(write), .i_cfg_primary(primary), .i_cfg_addr(addr),
    .i_cfg_wdata(wdata), .i_cfg_be(be), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .o_cfg_crs(crs), .o_cfg_target_retry(tretry), .i_test_mode_pin_zero(pin0),
    .i_test_mode_pin_one(pin1), .i_test_mode_pin_two(pin2), .i_mask_input_strap(mask_s),
    .i_reverse_mode_strap(rev), .i_discard_enable(disc_en), .i_fwd_discard_long(fwd_long),
    .i_rev_discard_long(rev_long), .i_retry_event(rty_ev), .i_retry_clear(rty_clr),
    .i_credit_freed(credit), .i_cfg_retry_start(crs_s), .i_cfg_retry_stop(crs_p),
    .i_cpl_start(cpl_s), .i_cpl_stop(cpl_p), .i_mem_upstream(mem_up), .o_fc_update(fc),
    .o_discard_active(dact), .o_discard_short(dshort), .o_discard_select(dsel),
    .o_in_order(ord), .o_traffic_class(tc), .o_loopback(lb), .o_cfg_retry_expired(crs_x),
    .o_cpl_expired(cpl_x));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    check(expq.size(), 0, "answers missing");
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // the monitor takes the oldest note whenever an answer shows
  always @(posedge clk) begin
    #2;
    fc_cnt = fc_cnt + (fc === 1'b1);
    if ((ack | crs | tretry) === 1'b1) begin
      if (expq.size() > 0) e = expq.pop_front();
      else e = '{3'h0, 1'b0, 32'h0, 32'h0};
      check({tretry, crs, ack}, e.kind, "answer kind");
      if (e.rd) check(rdata & e.mask, e.data & e.mask, "read data");
    end
  end

  function automatic logic [31:0] apply(input logic [31:0] wd, input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, 8'h00} & 32'hFFFE_8000;
    if (!rev) m[30] = 1'b0;
    // the status bit is write-one-to-clear, so it never takes the written value
    apply = (shadow & ~m & 32'hFFFE_FFFF) | (wd & m) |
            (shadow & 32'h0001_0000 & ~({8'h00, {8{b[2]}}, 16'h0} & wd));
  endfunction : apply

  task automatic acc(input logic w, input logic p, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] b);
    note_type t;
    t = '{3'h1, !w, (a == OFF) ? 32'hFFFF_8000 : 32'hFFFF_FFFF, (a == OFF) ? shadow : 32'h0};
    if (p && shadow[31]) t = '{rev ? 3'h4 : 3'h2, 1'b0, 32'h0, 32'h0};
    else if (w && a == OFF) shadow = apply(wd, b);
    expq.push_back(t);
    i_host.access(w, p, a, wd, b);
  endtask : acc

  task automatic levels;
    repeat (6) @(posedge clk);
    #2;
    check(ord, shadow[23], "order");
    check(dshort, shadow[20], "short");
    check(dact, disc_en & ~shadow[19], "discard");
    check(dsel, shadow[20] ? 8'h40 : {7'h0, rev ? rev_long : fwd_long}, "select");
    if (mem_up) check(tc, shadow[26] ? shadow[29:27] : 3'h0, "class");
    check(lb, shadow[30] & ~pin0 & pin1 & pin2 & mask_s & rev, "loop");
  endtask : levels

  task automatic pulses(input int cnt, input int which);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      #1;
      {credit, rty_ev, crs_s, cpl_s, cpl_p} = 5'h10 >> which;
      @(posedge clk);
      #1;
      {credit, rty_ev, crs_s, cpl_s, cpl_p} = 5'h00;
    end
  endtask : pulses

  // start a timer, optionally stop the completion timer, and look for one expiry near the count
  task automatic timer(input int which, input int cnt, input logic stop, input logic exp);
    logic seen;
    seen = 1'b0;
    pulses(1, which);
    if (stop) pulses(1, 4);
    for (n = 0; n < cnt + 8 && !seen; n++) begin
      @(posedge clk);
      #2;
      seen = ((which == 2) ? crs_x : cpl_x) === 1'b1;
    end
    check(seen && n >= cnt - 8, exp, "timer");
  endtask : timer

  initial begin
    #400us;
    errors++;
    give_verdict();
  end

  initial begin
    {rst, pin0, pin1, pin2, mask_s, rev} = 6'h3F;
    pin0 = 1'b0;
    {disc_en, fwd_long, rev_long, rty_ev, rty_clr, credit, crs_s, crs_p, cpl_s, cpl_p} = '0;
    {mem_up, errors, cmp_count, fc_cnt} = '0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    shadow = 32'h0920_0000;
    acc(0, 0, OFF, 0, 4'hF);
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      {disc_en, fwd_long, rev_long, mem_up} = d[3:0];
      d = $random(seed) & 32'h7FFF_FFFF;
      acc(1, d[4], OFF, d, d[3:0]);
      acc(0, i[0], OFF, 0, 4'hF);
      levels();
    end
    acc(0, 1, 8'h44, 32'hFFFF_FFFF, 4'hF);
    acc(1, 0, 8'h44, 32'hFFFF_FFFF, 4'hF);
    pin1 = 1'b0;
    acc(1, 0, OFF, shadow | 32'h4400_0000, 4'hF);
    levels();
    {pin1, rev} = 2'b10;
    // the direction strap needs its synchroniser to settle before the write
    repeat (4) @(posedge clk);
    acc(1, 0, OFF, shadow & 32'hBFFF_FFFF, 4'hF);
    levels();
    acc(1, 0, OFF, shadow | 32'h4000_0000, 4'hF);
    acc(1, 1, OFF, shadow | 32'h8000_0000, 4'hF);
    acc(0, 1, OFF, 0, 4'hF);
    acc(1, 1, OFF, 32'h0, 4'hF);
    rev = 1'b1;
    levels();
    acc(0, 1, OFF, 0, 4'hF);
    acc(0, 0, OFF, 0, 4'hF);
    acc(1, 0, OFF, 32'h0600_0000, 4'hF);
    for (int i = 0; i < 2; i++) begin
      acc(1, 0, OFF, shadow ^ 32'h0000_8000, 4'h2);
      fc_cnt = 0;
      pulses(4, 0);
      levels();
      check(fc_cnt, shadow[15] ? 4 : 2, "updates");
    end
    timer(2, 2500, 1'b0, 1'b1);
    timer(3, 100, 1'b0, 1'b1);
    timer(3, 100, 1'b1, 1'b0);
    acc(1, 0, OFF, 32'h0322_0000, 4'hF);
    timer(3, 200, 1'b0, 1'b0);
    pulses(1, 1);
    rty_clr = 1'b1;
    pulses(1, 1);
    rty_clr = 1'b0;
    pulses(255, 1);
    acc(0, 0, OFF, 0, 4'hF);
    pulses(1, 1);
    shadow[16] = 1'b1;
    acc(0, 0, OFF, 0, 4'hF);
    acc(1, 0, OFF, 32'h0, 4'hF);
    acc(0, 0, OFF, 0, 4'hF);
    acc(1, 0, OFF, 32'h0001_0000, 4'h4);
    acc(1, 0, OFF, shadow | 32'h8000_0000, 4'hF);
    acc(0, 0, OFF, 0, 4'hF);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    shadow = 32'h0920_0000;
    acc(0, 1, OFF, 0, 4'hF);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule : chip_control_upper_tb
